// [bmspx_pkg.sv]
// Package for the mono source and pattern expander: offsets, fields, types.
package bmspx_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_DADDR   = 8'h08;
    localparam logic [7:0] OFS_DPITCH  = 8'h0C;
    localparam logic [7:0] OFS_DSIZE   = 8'h10;
    localparam logic [7:0] OFS_PADDR   = 8'h14;
    localparam logic [7:0] OFS_SFG     = 8'h18;
    localparam logic [7:0] OFS_SBG     = 8'h1C;
    localparam logic [7:0] OFS_PFG     = 8'h20;
    localparam logic [7:0] OFS_PBG     = 8'h24;
    localparam logic [7:0] OFS_PMONO0  = 8'h28;
    localparam logic [7:0] OFS_PMONO1  = 8'h2C;
    localparam logic [7:0] OFS_CLIPX   = 8'h30;
    localparam logic [7:0] OFS_CLIPY   = 8'h34;
    localparam logic [7:0] OFS_SRCDATA = 8'h38;
    localparam logic [7:0] OFS_SRCCNT  = 8'h3C;
    // Control fields
    localparam int CTL_GO     = 0;
    localparam int CTL_OPC_LO = 4;   // opcode [7:4]
    localparam int CTL_ROP_LO = 8;   // rop [15:8]
    localparam int CTL_DEP_LO = 16;  // depth [17:16]
    localparam int CTL_DYN    = 18;
    localparam int CTL_SSEL   = 19;
    localparam int CTL_TRANS  = 20;
    localparam int CTL_CLIP   = 21;
    localparam int CTL_PACK   = 22;
    localparam int CTL_FP_LO  = 24;  // first pixel [26:24]
    localparam int CTL_VAL_LO = 28;  // vertical align [30:28]
    // Opcodes
    localparam logic [3:0] OPC_PATTERN_FILL = 4'h1;
    localparam logic [3:0] OPC_COORD_FILL   = 4'h2;
    localparam logic [3:0] OPC_GLYPH_DRAW   = 4'h3;
    localparam logic [3:0] OPC_COLOR_COPY   = 4'h4;
    localparam logic [3:0] OPC_MONO_PAT     = 4'h5;
    // Raster codes
    localparam logic [7:0] ROP_PAT_COPY = 8'hF0;
    localparam logic [7:0] ROP_SRC_COPY = 8'hCC;
    // Depth codes
    localparam logic [1:0] DEP_8  = 2'h0;
    localparam logic [1:0] DEP_16 = 2'h1;
    localparam logic [1:0] DEP_32 = 2'h2;
    // Limits
    localparam int SRC_MAX_BYTES = 128;
    localparam int SRC_WORDS     = SRC_MAX_BYTES / 4;
    localparam int PAT_MAX_BYTES = 256;
    localparam int PAT_WORDS     = PAT_MAX_BYTES / 4;
    localparam int PAT_DIM       = 8;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        BM_IDLE  = 3'b000,
        BM_PLOAD = 3'b001,
        BM_PIX   = 3'b011,
        BM_WR    = 3'b010,
        BM_DONE  = 3'b110
    } bmspx_state_e;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0]  be;
    } bmspx_mem_s;
endpackage

// [bmspx_core.sv]
// Mono source and pattern expander with AHB-Lite register slave.
//
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module bmspx_core
    import bmspx_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Frame buffer memory port
    output bmspx_mem_s       mem,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata
);
    logic [31:0] ctrl, daddr, dpitch, dsize, paddr, sfg, sbg, pfg, pbg;
    logic [31:0] pmono0, pmono1, clipx, clipy;
    logic [31:0] src_buf [SRC_WORDS];
    logic [31:0] pat_buf [PAT_WORDS];
    logic [5:0]  src_cnt;
    logic        busy, done_flag, src_ovf;
    bmspx_state_e st;

    // AHB address phase capture
    logic        ap_wr, ap_rd;
    logic [7:0]  ap_ofs;
    logic        ap_ok;
    // Only whole-word transfers are taken
    wire  logic  ahb_go = hsel && hready && htrans[1] && (hsize == 3'h2);
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ap_wr  <= 1'b0;
            ap_rd  <= 1'b0;
            ap_ofs <= 8'h00;
        end else begin
            ap_wr  <= ahb_go && hwrite;
            ap_rd  <= ahb_go && !hwrite;
            ap_ofs <= haddr[7:0];
        end
    end
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign ap_ok     = (ap_ofs[1:0] == 2'b00) && (ap_ofs <= OFS_SRCCNT);

    // Decoded opcode properties
    wire logic [3:0] opc     = ctrl[CTL_OPC_LO +: 4];
    wire logic [7:0] rop     = ctrl[CTL_ROP_LO +: 8];
    wire logic       src_mono = (opc == OPC_GLYPH_DRAW);
    wire logic       pat_mono = (opc == OPC_MONO_PAT);
    wire logic       use_src  = (rop != ROP_PAT_COPY);
    wire logic       use_pat  = (rop != ROP_SRC_COPY);
    wire logic [1:0] depth    = ctrl[CTL_DYN] ? ctrl[CTL_DEP_LO +: 2] : DEP_8;
    wire logic       go_wr    = ap_wr && ap_ofs == OFS_CTRL && hwdata[CTL_GO] && !busy;
    // Operand needs of the command being written, not of the old one
    wire logic [3:0] go_opc   = hwdata[CTL_OPC_LO +: 4];
    wire logic [7:0] go_rop   = hwdata[CTL_ROP_LO +: 8];
    wire logic       go_pld   = (go_rop != ROP_SRC_COPY) && (go_opc != OPC_MONO_PAT);

    // Register writes
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= RST_ZERO;   daddr <= RST_ZERO; dpitch <= RST_ZERO;
            dsize <= RST_ZERO;  paddr <= RST_ZERO; sfg <= RST_ZERO;
            sbg <= RST_ZERO;    pfg <= RST_ZERO;   pbg <= RST_ZERO;
            pmono0 <= RST_ZERO; pmono1 <= RST_ZERO;
            clipx <= RST_ZERO;  clipy <= RST_ZERO;
        end else if (ap_wr && !busy && ap_ok) begin
            case (ap_ofs)
                OFS_CTRL:   ctrl   <= hwdata;
                OFS_DADDR:  daddr  <= hwdata;
                OFS_DPITCH: dpitch <= hwdata;
                OFS_DSIZE:  dsize  <= hwdata;
                OFS_PADDR:  paddr  <= {hwdata[31:3], 3'b000};
                OFS_SFG:    sfg    <= hwdata;
                OFS_SBG:    sbg    <= hwdata;
                OFS_PFG:    pfg    <= hwdata;
                OFS_PBG:    pbg    <= hwdata;
                OFS_PMONO0: pmono0 <= hwdata;
                OFS_PMONO1: pmono1 <= hwdata;
                OFS_CLIPX:  clipx  <= hwdata;
                OFS_CLIPY:  clipy  <= hwdata;
                default: ;
            endcase
        end
    end

    // Inline source stream, capped at the inline limit
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            src_cnt <= 6'h00;
            src_ovf <= 1'b0;
        end else if (go_wr) begin
            src_ovf <= 1'b0;
        end else if (ap_wr && !busy && ap_ofs == OFS_SRCDATA) begin
            if (src_cnt < 6'(SRC_WORDS)) begin
                src_cnt <= src_cnt + 6'h01;
            end else begin
                src_ovf <= 1'b1;
            end
        end else if (st == BM_DONE) begin
            src_cnt <= 6'h00;
        end
    end
    always_ff @(posedge mclk) begin
        if (ap_wr && !busy && ap_ofs == OFS_SRCDATA && src_cnt < 6'(SRC_WORDS)) begin
            src_buf[src_cnt[4:0]] <= hwdata;
        end
    end

    // Read mux
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hrdata <= RST_ZERO;
        end else if (ahb_go && !hwrite) begin
            case (haddr[7:0])
                OFS_CTRL:   hrdata <= ctrl;
                OFS_STATUS: hrdata <= {29'h0, src_ovf, done_flag, busy};
                OFS_DADDR:  hrdata <= daddr;
                OFS_DPITCH: hrdata <= dpitch;
                OFS_DSIZE:  hrdata <= dsize;
                OFS_PADDR:  hrdata <= paddr;
                OFS_SFG:    hrdata <= sfg;
                OFS_SBG:    hrdata <= sbg;
                OFS_PFG:    hrdata <= pfg;
                OFS_PBG:    hrdata <= pbg;
                OFS_PMONO0: hrdata <= pmono0;
                OFS_PMONO1: hrdata <= pmono1;
                OFS_CLIPX:  hrdata <= clipx;
                OFS_CLIPY:  hrdata <= clipy;
                OFS_SRCCNT: hrdata <= {26'h0, src_cnt};
                default:    hrdata <= RST_ZERO;
            endcase
        end
    end

    // Walk counters
    logic [15:0] x_byte, y_line, x_pix;
    logic [2:0]  prow, pcol;
    logic [6:0]  pload_idx;
    logic [10:0] sbit;
    logic [31:0] line_addr;
    wire logic [15:0] width  = dsize[15:0];
    wire logic [15:0] height = dsize[31:16];
    wire logic [2:0]  bpp_b  = (depth == DEP_32) ? 3'd4 : (depth == DEP_16) ? 3'd2 : 3'd1;
    wire logic [6:0]  pat_w  = (depth == DEP_32) ? 7'd64 : (depth == DEP_16) ? 7'd32 : 7'd16;
    wire logic        last_x = (x_byte + 16'(bpp_b)) >= width;
    wire logic        last_y = (y_line + 16'h0001) >= height;
    wire logic [31:0] pix_addr = line_addr + 32'(x_byte);
    // Source bit of this pixel: bit-packed continues, else each line restarts at first pixel
    wire logic [10:0] src_bit_idx = sbit;
    wire logic [31:0] sword = src_buf[src_bit_idx[9:5]];
    wire logic [1:0]  sbyte_sel = src_bit_idx[4:3];
    wire logic [7:0]  sbyte = sword[8*sbyte_sel +: 8];
    wire logic        sbit_v = sbyte[3'd7 - src_bit_idx[2:0]];
    wire logic [63:0] pmono = {pmono1, pmono0};
    wire logic        pbit_v = pmono[{prow, 3'd7 - pcol}];
    // Colour pattern pixel fetch
    wire logic [7:0]  pidx = 8'({prow, pcol}) * 8'(bpp_b);
    wire logic [31:0] pword = pat_buf[pidx[7:2]];
    logic [31:0] pix_pat, pix_src, pix_out, next_wdata;
    logic        pix_keep;
    always_comb begin
        pix_src = sbit_v ? sfg : sbg;
        pix_pat = pat_mono ? (pbit_v ? pfg : pbg) : (pword >> (8 * pidx[1:0]));
        pix_out = use_src ? pix_src : pix_pat;
        pix_keep = 1'b1;
        if (ctrl[CTL_TRANS] && src_mono) begin
            pix_keep = sbit_v;
        end
        if (ctrl[CTL_CLIP] && src_mono) begin
            if (x_pix < clipx[15:0] || x_pix > clipx[31:16] ||
                y_line < clipy[15:0] || y_line > clipy[31:16]) begin
                pix_keep = 1'b0;
            end
        end
        next_wdata = pix_out << (8 * pix_addr[1:0]);
    end

    // Engine sequencer
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st <= BM_IDLE;   busy <= 1'b0;  done_flag <= 1'b0;
            x_byte <= 16'h0; y_line <= 16'h0; x_pix <= 16'h0;
            prow <= 3'h0;    pcol <= 3'h0;    pload_idx <= 7'h0;
            sbit <= 11'h0;   line_addr <= RST_ZERO;
            mem <= '0;
        end else begin
            case (st)
                BM_IDLE: begin
                    if (go_wr) begin
                        busy      <= 1'b1;
                        done_flag <= 1'b0;
                        line_addr <= daddr;
                        x_byte <= 16'h0; y_line <= 16'h0; x_pix <= 16'h0;
                        prow <= hwdata[CTL_VAL_LO +: 3];
                        pcol <= 3'h0;
                        sbit <= {8'h0, hwdata[CTL_FP_LO +: 3]};
                        pload_idx <= 7'h0;
                        // Pattern fetched from memory only when colour and used
                        st <= go_pld ? BM_PLOAD : BM_PIX;
                    end
                end
                BM_PLOAD: begin
                    mem.req  <= 1'b1;
                    mem.we   <= 1'b0;
                    mem.addr <= paddr + {23'h0, pload_idx, 2'b00};
                    if (mem.req && mem_ack) begin
                        pat_buf[pload_idx[5:0]] <= mem_rdata;
                        mem.req <= 1'b0;
                        if (pload_idx + 7'h1 >= pat_w) begin
                            st <= BM_PIX;
                        end
                        pload_idx <= pload_idx + 7'h1;
                    end
                end
                BM_PIX: begin
                    if (height == 16'h0 || width == 16'h0) begin
                        st <= BM_DONE;
                    end else begin
                        mem.req   <= pix_keep;
                        mem.we    <= 1'b1;
                        mem.addr  <= pix_addr;
                        mem.wdata <= next_wdata;
                        mem.be    <= 4'((bpp_b == 3'd4) ? 4'hF : (bpp_b == 3'd2) ?
                                     (4'h3 << pix_addr[1:0]) : (4'h1 << pix_addr[1:0]));
                        st <= BM_WR;
                    end
                end
                BM_WR: begin
                    if (!mem.req || mem_ack) begin
                        mem.req <= 1'b0;
                        sbit    <= sbit + 11'h1;
                        if (last_x) begin
                            x_byte <= 16'h0;
                            x_pix  <= 16'h0;
                            pcol   <= 3'h0;
                            prow   <= prow + 3'h1;
                            line_addr <= line_addr + dpitch;
                            // Unpacked lines restart on the next 16-bit word
                            if (!ctrl[CTL_PACK]) begin
                                sbit <= {sbit[10:4] + 7'h1, 1'b0, ctrl[CTL_FP_LO +: 3]};
                            end
                            y_line <= y_line + 16'h1;
                            st <= last_y ? BM_DONE : BM_PIX;
                        end else begin
                            x_byte <= x_byte + 16'(bpp_b);
                            x_pix  <= x_pix + 16'h1;
                            pcol   <= pcol + 3'h1;
                            st <= BM_PIX;
                        end
                    end
                end
                BM_DONE: begin
                    busy      <= 1'b0;
                    done_flag <= 1'b1;
                    st        <= BM_IDLE;
                end
                default: st <= BM_IDLE;
            endcase
        end
    end

    // Checks
    property p_no_src_overrun;
        @(posedge mclk) disable iff (!rst_b) src_cnt <= 6'(SRC_WORDS);
    endproperty
    a_no_src_overrun: assert property (p_no_src_overrun) else $error("src overrun");
    property p_pat_aligned;
        @(posedge mclk) disable iff (!rst_b) paddr[2:0] == 3'b000;
    endproperty
    a_pat_aligned: assert property (p_pat_aligned) else $error("pat addr low bits");
    property p_no_pload_cc;
        @(posedge mclk) disable iff (!rst_b) (st == BM_PLOAD) |-> use_pat;
    endproperty
    a_no_pload_cc: assert property (p_no_pload_cc) else $error("pattern read on CCh");
    property p_pitch_step;
        @(posedge mclk) disable iff (!rst_b)
            (st == BM_WR && (!mem.req || mem_ack) && last_x)
            |=> line_addr == $past(line_addr) + $past(dpitch);
    endproperty
    a_pitch_step: assert property (p_pitch_step) else $error("pitch step");
    property p_row_wrap;
        @(posedge mclk) disable iff (!rst_b)
            (st == BM_WR && (!mem.req || mem_ack) && last_x) |=> prow == $past(prow) + 3'h1;
    endproperty
    a_row_wrap: assert property (p_row_wrap) else $error("row index");
    property p_all_written;
        @(posedge mclk) disable iff (!rst_b)
            (st == BM_PIX && !ctrl[CTL_TRANS] && !ctrl[CTL_CLIP] && width != 16'h0
             && height != 16'h0) |=> mem.req && mem.we;
    endproperty
    a_all_written: assert property (p_all_written) else $error("pixel dropped");
    property p_clip;
        @(posedge mclk) disable iff (!rst_b)
            (st == BM_PIX && ctrl[CTL_CLIP] && src_mono && x_pix > clipx[31:16]) |=> !mem.req;
    endproperty
    a_clip: assert property (p_clip) else $error("clip write");
    sequence s_start;
        st == BM_IDLE && go_wr;
    endsequence
    property p_first_addr;
        @(posedge mclk) disable iff (!rst_b) s_start |=> line_addr == $past(daddr);
    endproperty
    a_first_addr: assert property (p_first_addr) else $error("first address");
    sequence s_pix_mid;
        st == BM_WR && (!mem.req || mem_ack) && !last_x;
    endsequence
    sequence s_line_unpacked;
        st == BM_WR && (!mem.req || mem_ack) && last_x && !ctrl[CTL_PACK];
    endsequence
    sequence s_step_packed;
        st == BM_WR && (!mem.req || mem_ack) && ctrl[CTL_PACK];
    endsequence
    property p_col_step;
        @(posedge mclk) disable iff (!rst_b)
            s_pix_mid |=> pcol == $past(pcol) + 3'h1 && x_pix == $past(x_pix) + 16'h1;
    endproperty
    a_col_step: assert property (p_col_step) else $error("column index");
    property p_line_restart;
        @(posedge mclk) disable iff (!rst_b)
            s_line_unpacked |=> sbit[3] == 1'b0 && sbit[2:0] == ctrl[CTL_FP_LO +: 3];
    endproperty
    a_line_restart: assert property (p_line_restart) else $error("line start bit");
    property p_packed_cont;
        @(posedge mclk) disable iff (!rst_b) s_step_packed |=> sbit == $past(sbit) + 11'h1;
    endproperty
    a_packed_cont: assert property (p_packed_cont) else $error("packed source gap");
    property p_req_hold;
        @(posedge mclk) disable iff (!rst_b)
            mem.req && !mem_ack |=> mem.req && mem.addr == $past(mem.addr);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped");
    property p_mono_pat_local;
        @(posedge mclk) disable iff (!rst_b) (st == BM_PLOAD) |-> !pat_mono;
    endproperty
    a_mono_pat_local: assert property (p_mono_pat_local) else $error("mono pattern read");
    property p_only_pat_reads;
        @(posedge mclk) disable iff (!rst_b) (mem.req && !mem.we) |-> st == BM_PLOAD;
    endproperty
    a_only_pat_reads: assert property (p_only_pat_reads) else $error("source read");
    property p_pload_len;
        @(posedge mclk) disable iff (!rst_b)
            (st == BM_PLOAD && mem.req && mem_ack && (pload_idx + 7'h1 >= pat_w))
            |=> st == BM_PIX;
    endproperty
    a_pload_len: assert property (p_pload_len) else $error("pattern length");
endmodule // bmspx_core
`default_nettype wire

// [bmspx_fb_model.sv]
// Frame buffer memory model answering the expander's memory port.
`timescale 1ns/1ps
`default_nettype none
module bmspx_fb_model
    import bmspx_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // Memory port
    input  wire bmspx_mem_s  mem,
    output logic             mem_ack,
    output logic      [31:0] mem_rdata
);
    logic [7:0]  bytes [int unsigned];  // Linear byte-addressed store
    int          lat      = 0;
    int          nreads   = 0;
    int          wait_cnt = 0;
    int unsigned base;

    function automatic logic [7:0] peek(input int unsigned a);
        return bytes.exists(a) ? bytes[a] : 8'hEE;
    endfunction

    // Idle read data toggles so stale values never look valid
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mem_ack   <= 1'b0;
            mem_rdata <= 32'h5A5A_A5A5;
            wait_cnt  = 0;
        end else if (mem_ack || !mem.req) begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_cnt  = 0;
        end else if (wait_cnt < lat) begin
            wait_cnt++;
            mem_rdata <= ~mem_rdata;
        end else begin
            base = {mem.addr[31:2], 2'b00};
            mem_ack <= 1'b1;
            for (int i = 0; i < 4; i++) begin
                if (mem.we && mem.be[i])
                    bytes[base + i] = mem.wdata[8 * i +: 8];
                mem_rdata[8 * i +: 8] <= peek(base + i);
            end
            if (!mem.we)
                nreads++;
        end
    end
endmodule // bmspx_fb_model
`default_nettype wire

// [test_blit_mono_source_pattern_expander.sv]
// Self-checking testbench for the mono source and pattern expander.
`timescale 1ns/1ps
`default_nettype none
module test_blit_mono_source_pattern_expander
    import bmspx_pkg::*;
;
    localparam logic [31:0] DST = 32'h0000_2004;
    localparam logic [31:0] PAT = 32'h0010_0000;  // Size-aligned pattern base
    logic        mclk   = 1'b0;
    logic        rst_b  = 1'b0;
    logic        hsel   = 1'b0;
    logic [31:0] haddr  = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize  = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    bmspx_mem_s  mem;
    logic        mem_ack;
    logic [31:0] mem_rdata;
    int          num_errors = 0;
    int          num_checks = 0;
    int          mode, bpp, fp, clp, trn, pk;
    logic [31:0] rd, fg, bg, src, src2, pm0, pm1;

    bmspx_core dut (
        .mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mem(mem),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    bmspx_fb_model fbm (
        .mclk(mclk), .rst_b(rst_b), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    always #12.5 mclk = ~mclk;

    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One single-word transfer; read data lands in rd
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    function automatic logic [31:0] ctl(input logic [3:0] opc, input logic [7:0] rop,
                                        input logic [1:0] dep, input logic [31:0] fl);
        return fl | (32'(opc) << CTL_OPC_LO) | (32'(rop) << CTL_ROP_LO) | (32'(dep) << CTL_DEP_LO);
    endfunction

    task automatic run(input logic [31:0] ctrl);
        int n;
        n = 0;
        ahb(1'b1, OFS_CTRL, ctrl | 32'h1);
        repeat (2) @(posedge mclk);
        do begin
            ahb(1'b0, OFS_STATUS, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 4000);
        check({31'h0, rd[1]}, 32'h1);
    endtask

    // Expected destination byte; EE marks a byte left unwritten
    function automatic logic [7:0] exp_b(input int y, input int xb);
        int x, k;
        logic b;
        logic [31:0] c;
        logic [63:0] s;
        s = {src2, src};
        x = xb / bpp;
        if (mode == 0)
            return 8'((((y % 8) * 8 + x % 8) * bpp + xb % bpp) % 224 + 1);
        if (mode == 1)
            b = (y % 8 < 4) ? pm0[8 * (y % 8) + 7 - x % 8] : pm1[8 * (y % 8 - 4) + 7 - x % 8];
        else begin
            k = (pk != 0) ? fp + y * 8 + x : 16 * y + fp + x;
            b = s[8 * (k / 8) + 7 - k % 8];
            if ((clp != 0 && (x < 2 || x > 5 || y < 1 || y > 2)) || (trn != 0 && !b))
                return 8'hEE;
        end
        c = b ? fg : bg;
        return c[8 * (xb % bpp) +: 8];
    endfunction

    task automatic setup(input int w, input int h, input int lat);
        fbm.bytes.delete();
        fbm.nreads = 0;
        fbm.lat = lat;
        ahb(1'b1, OFS_DADDR, DST);
        ahb(1'b1, OFS_DPITCH, 32'h40);
        ahb(1'b1, OFS_DSIZE, {16'(h), 16'(w)});
        ahb(1'b1, mode == 2 ? OFS_SFG : OFS_PFG, fg);
        ahb(1'b1, mode == 2 ? OFS_SBG : OFS_PBG, bg);
        ahb(1'b1, mode == 2 ? OFS_PFG : OFS_SFG, ~fg);  // Other colour pair must not leak
        ahb(1'b1, mode == 2 ? OFS_PBG : OFS_SBG, ~bg);
    endtask

    task automatic verify(input int w, input int h, input int reads);
        for (int y = 0; y < h; y++)
            for (int xb = 0; xb <= w; xb++)
                check({24'h0, fbm.peek(DST + y * 64 + xb)}, {24'h0, xb == w ? 8'hEE : exp_b(y, xb)});
        check(32'(fbm.nreads), 32'(reads));
    endtask

    task automatic t_regs;
        ahb(1'b0, OFS_PADDR, 32'h0);
        check(rd, RST_ZERO);
        ahb(1'b1, OFS_DPITCH, 32'h0000_0400);
        ahb(1'b0, OFS_DPITCH, 32'h0);
        check(rd, 32'h0000_0400);
        ahb(1'b1, 8'h40, 32'hFFFF_FFFF);
        ahb(1'b0, 8'h40, 32'h0);
        check(rd, 32'h0);
        $display("test registers done");
    endtask

    task automatic t_colour_pat(input logic [3:0] opc, input logic [1:0] dep, input int lat);
        mode = 0;
        bpp = 1 << dep;
        setup(24, 10, lat);
        for (int i = 0; i < 64 * bpp; i++)
            fbm.bytes[PAT + i] = 8'(i % 224 + 1);
        ahb(1'b1, OFS_PADDR, PAT | 32'h5);
        run(ctl(opc, ROP_PAT_COPY, dep, 32'h1 << CTL_DYN));
        verify(24, 10, 16 * bpp);
        ahb(1'b0, OFS_PADDR, 32'h0);
        check(rd, PAT);
        $display("test colour pattern depth %0d done", dep);
    endtask

    task automatic t_mono_pat;
        mode = 1;
        bpp = 2;
        fg = 32'h0000_1234;
        bg = 32'h0000_ABCD;
        pm0 = 32'h8142_2418;
        pm1 = 32'h0FF0_C33C;
        setup(16, 9, 2);
        ahb(1'b1, OFS_PMONO0, pm0);
        ahb(1'b1, OFS_PMONO1, pm1);
        run(ctl(OPC_MONO_PAT, ROP_PAT_COPY, DEP_16, 32'h1 << CTL_DYN));
        verify(16, 9, 0);
        $display("test mono pattern done");
    endtask

    task automatic t_glyph(input int t, input int c, input int lat, input int p);
        mode = 2;
        bpp = 1;
        fp = 3;
        trn = t;
        clp = c;
        pk = p;
        fg = 32'h0000_0033;
        bg = 32'h0000_0044;
        src = 32'hA5C3_3C96;
        src2 = 32'h5A0F_F0E1;
        setup(8, 3, lat);
        ahb(1'b1, OFS_CLIPX, 32'h0005_0002);
        ahb(1'b1, OFS_CLIPY, 32'h0002_0001);
        // Inline source starts a fresh, aligned buffer
        ahb(1'b1, OFS_SRCDATA, src);
        ahb(1'b1, OFS_SRCDATA, src2);
        run(ctl(OPC_GLYPH_DRAW, ROP_SRC_COPY, DEP_8, (32'h1 << CTL_SSEL) | (32'(p) << CTL_PACK)
            | (32'(t) << CTL_TRANS) | (32'(c) << CTL_CLIP) | (32'(fp) << CTL_FP_LO)));
        verify(8, 3, 0);
        $display("test glyph transparency %0d clip %0d packed %0d done", t, c, p);
    endtask

    task automatic t_overflow;
        for (int i = 0; i < 32; i++)
            ahb(1'b1, OFS_SRCDATA, 32'(i));
        ahb(1'b0, OFS_STATUS, 32'h0);
        check({31'h0, rd[2]}, 32'h0);
        ahb(1'b1, OFS_SRCDATA, 32'h0000_00FF);
        ahb(1'b0, OFS_STATUS, 32'h0);
        check({31'h0, rd[2]}, 32'h1);
        $display("test source overflow done");
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        t_regs;
        t_colour_pat(OPC_PATTERN_FILL, DEP_8, 0);
        t_colour_pat(OPC_COORD_FILL, DEP_16, 3);
        t_colour_pat(OPC_PATTERN_FILL, DEP_32, 1);
        t_mono_pat;
        t_glyph(0, 0, 0, 1);
        t_glyph(1, 1, 2, 1);
        t_glyph(0, 0, 1, 0);
        t_overflow;
        close_out;
    end

    initial begin
        repeat (50000) @(posedge mclk);
        num_errors++;
        close_out;
    end
endmodule // test_blit_mono_source_pattern_expander
`default_nettype wire
